// *** hw/fcsu_bus_cycle.sv ***
`timescale 1ns/1ps
`include "fcsu_map.svh"
module fcsu_bus_cycle
  import fcsu_pkg::*;
#(
  parameter int SETUP_CYC = 1,
  parameter int PULSE_CYC = 4
) (
  input  wire logic        i_core_clk, // core clock
  input  wire logic        i_rst_b,    // synchronised reset, active low
  input  wire logic        i_go,       // start one pin cycle
  input  wire fcsu_req_t   i_req,      // cycle request
  input  wire logic [15:0] i_dq,       // data pins in
  output logic             o_done,     // one-cycle pulse at end
  output logic [15:0]      o_rdata,    // data sampled on a read
  output logic [21:0]      o_addr,     // address pins
  output logic             o_ce_b,     // chip enable, active low
  output logic             o_oe_b,     // output enable, active low
  output logic             o_we_b,     // write enable, active low
  output logic [15:0]      o_dq,       // data pins out
  output logic             o_dq_oe     // high while driving data pins
);
  fcsu_cyc_t  state_reg;
  logic [7:0] cnt_reg;
  logic       wr_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= CY_IDLE;
      cnt_reg   <= 8'h00;
      wr_reg    <= 1'b0;
    end else begin
      unique case (state_reg)
        CY_IDLE: begin
          if (i_go) begin
            state_reg <= CY_SETUP;
            wr_reg    <= i_req.wr;
            cnt_reg   <= 8'(SETUP_CYC - 1);
          end
        end
        CY_SETUP: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= CY_PULSE;
            cnt_reg   <= 8'(PULSE_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        CY_PULSE: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= CY_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        CY_HOLD: state_reg <= CY_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pins: strobes drop only after address and data have settled
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_addr  <= 22'h000000;
      o_ce_b  <= 1'b1;
      o_oe_b  <= 1'b1;
      o_we_b  <= 1'b1;
      o_dq    <= 16'h0000;
      o_dq_oe <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      unique case (state_reg)
        CY_IDLE: begin
          if (i_go) begin
            o_addr  <= i_req.addr;
            o_ce_b  <= 1'b0;
            o_dq    <= i_req.data;
            o_dq_oe <= i_req.wr;
          end
        end
        CY_SETUP: begin
          if (cnt_reg == 8'h00) begin
            o_we_b <= !wr_reg;
            o_oe_b <= wr_reg;
          end
        end
        CY_PULSE: begin
          if (cnt_reg == 8'h00) begin
            if (!wr_reg) begin
              o_rdata <= i_dq;
            end
            o_we_b <= 1'b1;
            o_oe_b <= 1'b1;
          end
        end
        CY_HOLD: begin
          o_ce_b  <= 1'b1;
          o_dq_oe <= 1'b0;
          o_done  <= 1'b1;
        end
      endcase
    end
  end

  a_no_bus_fight: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_dq_oe |-> o_oe_b)
    else $error("data pins driven while flash output enabled");
endmodule

// *** hw/fcsu_ctrl.sv ***
`timescale 1ns/1ps
`include "fcsu_map.svh"
// Overview of operation
// RL1 - device sequencer sets error bits; only clear-status code 50 clears them
// RL2 - code 90 puts device in identifier mode
// RL3 - lock set-up not followed by a confirm code flags sequence error
// RL4 - 60 then 01 locks the addressed block
// RL5 - 60 then 2F locks down the addressed block
// RL6 - code 98 puts device in query mode
// RL7 - protection program: set-up write, then address and data write
// RL8 - after programming reads give status; issue read-array before array reads
// RL9 - alternate program code 10 acts like program set-up
// RL10 - never issue unassigned or reserved command codes; the erase confirm is sent from wdata_reg unchecked
// RL11 - status bit 7 ready; bits 6..1 suspend, errors, supply, lock
// RL12 - check ready bit before judging program or erase error bits
// RL13 - erase suspend sets ready and erase-suspended until resume
// RL14 - erase error after maximum pulses without verify
// RL15 - program error when a location fails to program
// RL16 - supply-low bit checked only at entry and before verify
// RL17 - program suspend sets ready and program-suspended until resume
// RL18 - program or erase on locked block sets lock fault and aborts
// RL19 - status bit zero is reserved; mask it when polling
// RL20 - sequence error shows program error, erase error and ready together
// RL21 - 60 then D0 unlocks the block unless it is locked down
// RL22 - code 70 makes every read return status; entered on program start
// RL23 - code FF returns the device to array reads
// RL24 - command codes ride the low data byte only
module fcsu_ctrl
  import fcsu_pkg::*;
#(
  parameter int CLK_MHZ = `FCSU_CLK_MHZ
) (
  input  wire logic        i_core_clk, // core clock, 40 MHz
  input  wire logic        i_rst_b,    // reset, active low, asynchronous
  input  wire logic        hsel,       // ahb slave select
  input  wire logic [31:0] haddr,      // ahb address
  input  wire logic [1:0]  htrans,     // ahb transfer type
  input  wire logic        hwrite,     // ahb write
  input  wire logic [2:0]  hsize,      // ahb size, word only
  input  wire logic [31:0] hwdata,     // ahb write data
  input  wire logic        hready,     // ahb bus ready
  output logic             hreadyout,  // ahb ready out
  output logic             hresp,      // ahb response, always okay
  output logic [31:0]      hrdata,     // ahb read data
  input  wire logic [15:0] i_dq,       // flash data pins in
  output logic [21:0]      o_addr,     // flash address pins
  output logic             o_ce_b,     // flash chip enable
  output logic             o_oe_b,     // flash output enable
  output logic             o_we_b,     // flash write enable
  output logic [15:0]      o_dq,       // flash data pins out
  output logic             o_dq_oe     // high while driving flash data
);
  localparam int SETUP_CYC =
    (`FCSU_T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC =
    (`FCSU_T_PULSE_NS * CLK_MHZ + 999) / 1000;

  logic       rst_meta_reg;
  logic       rst_b_sync;
  fcsu_seq_t  state_reg;
  logic       issued_reg;
  logic       wr_pend_reg;
  logic [7:0] wr_ofs_reg;
  logic [7:0] code_reg;
  fcsu_kind_t kind_reg;
  logic [21:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0] fstat_reg;
  logic       stale_reg;
  logic       reject_reg;
  logic       done_reg;
  logic       cyc_done;
  logic [15:0] cyc_rdata;
  fcsu_req_t  req;
  logic       cyc_go;
  logic       cmd_wr;
  logic       cmd_ok;
  logic       accept;
  logic       finish;
  logic       prog_kind;
  fcsu_kind_t new_kind;
  logic [7:0] new_code;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_b_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_b_sync   <= rst_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ahb slave: zero wait, read data registered in the address phase
  always_ff @(posedge i_core_clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
      hrdata      <= `FCSU_RESET_VAL;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      hreadyout   <= 1'b1;
      wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
      wr_ofs_reg  <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        unique case (haddr[7:0])
          `FCSU_OFS_CMD:   hrdata <= {22'h0, kind_reg, code_reg};
          `FCSU_OFS_ADDR:  hrdata <= {10'h0, addr_reg};
          `FCSU_OFS_WDATA: hrdata <= {16'h0, wdata_reg};
          `FCSU_OFS_STAT: begin
            hrdata <= {24'h0, stale_reg,
              fstat_reg[`FCSU_FS_READY] & fstat_reg[`FCSU_FS_LOCKF],
              fstat_reg[`FCSU_FS_READY] & fstat_reg[`FCSU_FS_PERR] &
                fstat_reg[`FCSU_FS_EERR],
              fstat_reg[`FCSU_FS_READY] & fstat_reg[`FCSU_FS_EERR],
              fstat_reg[`FCSU_FS_READY] & fstat_reg[`FCSU_FS_PERR],
              done_reg, reject_reg, state_reg != ST_IDLE}; // RL12
          end
          `FCSU_OFS_RDATA: hrdata <= {16'h0, rdata_reg};
          `FCSU_OFS_FSTAT: hrdata <= {24'h0, fstat_reg};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign new_code = hwdata[`FCSU_CMD_CODE_LSB +: 8];
  assign new_kind = fcsu_kind_t'(hwdata[`FCSU_CMD_KIND_LSB +: 2]);
  assign cmd_wr   = wr_pend_reg && (wr_ofs_reg == `FCSU_OFS_CMD);

  // only assigned codes reach the pins, except the erase confirm, which is sent from wdata_reg unchecked
  always_comb begin
    cmd_ok = 1'b1;
    if (new_kind == KIND_SINGLE) begin
      cmd_ok = new_code inside {`FCSU_C_READ_ARRAY, `FCSU_C_READ_STAT,
        `FCSU_C_CLR_STAT, `FCSU_C_READ_ID, `FCSU_C_QUERY,
        `FCSU_C_SUSPEND, `FCSU_C_RESUME}; // RL10
    end else if (new_kind == KIND_TWO) begin
      cmd_ok = new_code inside {`FCSU_C_PROG, `FCSU_C_PROG_ALT,
        `FCSU_C_ERASE, `FCSU_C_LOCK_SETUP, `FCSU_C_PROT_PROG}; // RL10
      if (new_code == `FCSU_C_LOCK_SETUP) begin
        cmd_ok = wdata_reg[7:0] inside {`FCSU_C_LOCK, `FCSU_C_UNLOCK,
          `FCSU_C_LOCK_DOWN}; // RL3
      end
    end
  end

  assign accept = cmd_wr && (state_reg == ST_IDLE) && cmd_ok;

  always_ff @(posedge i_core_clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      code_reg  <= 8'h00;
      kind_reg  <= KIND_SINGLE;
      addr_reg  <= 22'h000000;
      wdata_reg <= 16'h0000;
    end else if (wr_pend_reg) begin
      if (accept) begin
        code_reg <= new_code;
        kind_reg <= new_kind;
      end
      if (wr_ofs_reg == `FCSU_OFS_ADDR && state_reg == ST_IDLE) begin
        addr_reg <= hwdata[21:0];
      end
      if (wr_ofs_reg == `FCSU_OFS_WDATA && state_reg == ST_IDLE) begin
        wdata_reg <= hwdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command sequencer
  assign prog_kind = code_reg inside {`FCSU_C_PROG, `FCSU_C_PROG_ALT,
    `FCSU_C_PROT_PROG, `FCSU_C_ERASE}; // RL7 RL9
  assign cyc_go = (state_reg != ST_IDLE) && !issued_reg;

  always_comb begin
    req.wr   = !(state_reg inside {ST_READ, ST_PRD});
    req.addr = addr_reg;
    unique case (state_reg)
      ST_SECOND: req.data = wdata_reg;
      ST_FIX:    req.data = {8'h00, `FCSU_C_READ_ARRAY};
      ST_PWR:    req.data = {8'h00, `FCSU_C_READ_STAT};
      default:   req.data = {8'h00, code_reg}; // RL24
    endcase
  end

  assign finish = cyc_done && (
    (state_reg == ST_FIRST && kind_reg != KIND_TWO) ||
    (state_reg == ST_SECOND && !prog_kind) ||
    (state_reg == ST_READ) ||
    (state_reg == ST_PRD && cyc_rdata[`FCSU_FS_READY]));

  always_ff @(posedge i_core_clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      state_reg  <= ST_IDLE;
      issued_reg <= 1'b0;
    end else begin
      if (cyc_go) begin
        issued_reg <= 1'b1;
      end else if (cyc_done) begin
        issued_reg <= 1'b0;
      end
      unique case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            unique case (new_kind)
              KIND_READ: state_reg <= stale_reg ? ST_FIX : ST_READ; // RL8
              KIND_POLL: state_reg <= ST_PWR;
              default:   state_reg <= ST_FIRST;
            endcase
          end
        end
        ST_FIRST: begin
          if (cyc_done) begin
            state_reg <= (kind_reg == KIND_TWO) ? ST_SECOND : ST_IDLE;
          end
        end
        ST_SECOND: begin
          if (cyc_done) begin
            state_reg <= prog_kind ? ST_PWR : ST_IDLE; // RL8
          end
        end
        ST_FIX:  if (cyc_done) state_reg <= ST_READ;
        ST_READ: if (cyc_done) state_reg <= ST_IDLE;
        ST_PWR:  if (cyc_done) state_reg <= ST_PRD;
        // each new read toggles the strobes, giving a fresh status word
        ST_PRD:  if (finish) state_reg <= ST_IDLE; // RL12
      endcase
    end
  end

  // any pin write but read-array is taken to leave the device out of array mode
  always_ff @(posedge i_core_clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      stale_reg <= 1'b0;
    end else if (cyc_done && req.wr) begin
      stale_reg <= (req.data[7:0] != `FCSU_C_READ_ARRAY); // RL8
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      rdata_reg <= 16'h0000;
      fstat_reg <= 8'h00;
    end else if (cyc_done) begin
      if (state_reg == ST_READ) begin
        rdata_reg <= cyc_rdata;
      end
      if (state_reg == ST_PRD) begin
        fstat_reg <= {cyc_rdata[7:1], 1'b0}; // RL19
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      reject_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      if (cmd_wr) begin
        reject_reg <= !accept; // RL10
      end
      if (finish) begin
        done_reg <= 1'b1;
      end else if (accept) begin
        done_reg <= 1'b0;
      end
    end
  end

  fcsu_bus_cycle #(
    .SETUP_CYC (SETUP_CYC),
    .PULSE_CYC (PULSE_CYC)
  ) u_cycle (
    .i_core_clk (i_core_clk),
    .i_rst_b    (rst_b_sync),
    .i_go       (cyc_go),
    .i_req      (req),
    .i_dq       (i_dq),
    .o_done     (cyc_done),
    .o_rdata    (cyc_rdata),
    .o_addr     (o_addr),
    .o_ce_b     (o_ce_b),
    .o_oe_b     (o_oe_b),
    .o_we_b     (o_we_b),
    .o_dq       (o_dq),
    .o_dq_oe    (o_dq_oe)
  );

  //////////////////////////////////////////////////////////////////////////
  sequence s_stale_read;
    state_reg == ST_IDLE && accept && new_kind == KIND_READ && stale_reg;
  endsequence

  sequence s_fix_done;
    state_reg == ST_FIX && cyc_done;
  endsequence

  a_fix_before_read: assert property (@(posedge i_core_clk) // RL8
    disable iff (!rst_b_sync)
    s_stale_read |=> state_reg == ST_FIX)
    else $error("array read issued without read-array first");

  a_fix_then_array: assert property (@(posedge i_core_clk) // RL8
    disable iff (!rst_b_sync)
    s_fix_done |=> state_reg == ST_READ && !stale_reg)
    else $error("read-array did not lead to the array read");

  a_poll_after_prog: assert property (@(posedge i_core_clk) // RL8
    disable iff (!rst_b_sync)
    state_reg == ST_SECOND && cyc_done && prog_kind |=> state_reg == ST_PWR)
    else $error("no status poll after program or erase start");

  a_reserved_refused: assert property (@(posedge i_core_clk) // RL10
    disable iff (!rst_b_sync)
    cmd_wr && !cmd_ok && state_reg == ST_IDLE
      |=> reject_reg && $stable(state_reg))
    else $error("reserved command code not refused");

  a_poll_ends_ready: assert property (@(posedge i_core_clk) // RL12
    disable iff (!rst_b_sync)
    state_reg == ST_PRD && cyc_done ##1 state_reg == ST_IDLE
      |-> fstat_reg[`FCSU_FS_READY])
    else $error("status poll ended while device busy");

  a_status_masked: assert property (@(posedge i_core_clk) // RL19
    disable iff (!rst_b_sync)
    $rose(done_reg) |-> fstat_reg[`FCSU_FS_RSVD] == 1'b0)
    else $error("reserved status bit not masked");
endmodule

// *** hw/fcsu_map.svh ***
`ifndef FCSU_MAP_SVH
`define FCSU_MAP_SVH
// controller register offsets (byte addresses, one word each)
`define FCSU_OFS_CMD    8'h00
`define FCSU_OFS_ADDR   8'h04
`define FCSU_OFS_WDATA  8'h08
`define FCSU_OFS_STAT   8'h0c
`define FCSU_OFS_RDATA  8'h10
`define FCSU_OFS_FSTAT  8'h14
// command register fields
`define FCSU_CMD_CODE_LSB 0
`define FCSU_CMD_KIND_LSB 8
// controller status fields
`define FCSU_ST_BUSY    0
`define FCSU_ST_REJECT  1
`define FCSU_ST_DONE    2
`define FCSU_ST_PERR    3
`define FCSU_ST_EERR    4
`define FCSU_ST_SEQERR  5
`define FCSU_ST_LOCKF   6
`define FCSU_ST_STALE   7
// flash status bit positions
`define FCSU_FS_READY   7
`define FCSU_FS_ESUSP   6
`define FCSU_FS_EERR    5
`define FCSU_FS_PERR    4
`define FCSU_FS_VLOW    3
`define FCSU_FS_PSUSP   2
`define FCSU_FS_LOCKF   1
`define FCSU_FS_RSVD    0
// flash command codes
`define FCSU_C_READ_ARRAY 8'hff
`define FCSU_C_READ_STAT  8'h70
`define FCSU_C_CLR_STAT   8'h50
`define FCSU_C_READ_ID    8'h90
`define FCSU_C_QUERY      8'h98
`define FCSU_C_SUSPEND    8'hb0
`define FCSU_C_RESUME     8'hd0
`define FCSU_C_PROG       8'h40
`define FCSU_C_PROG_ALT   8'h10
`define FCSU_C_ERASE      8'h20
`define FCSU_C_LOCK_SETUP 8'h60
`define FCSU_C_PROT_PROG  8'hc0
`define FCSU_C_LOCK       8'h01
`define FCSU_C_UNLOCK     8'hd0
`define FCSU_C_LOCK_DOWN  8'h2f
// pin timing and ahb read-data reset value
`define FCSU_CLK_MHZ      40
`define FCSU_T_SETUP_NS   25
`define FCSU_T_PULSE_NS   100
`define FCSU_RESET_VAL    32'h0000_0000
`endif

// *** hw/fcsu_pkg.sv ***
package fcsu_pkg;
  typedef enum logic [1:0] {
    KIND_SINGLE = 2'h0,
    KIND_TWO    = 2'h1,
    KIND_READ   = 2'h2,
    KIND_POLL   = 2'h3
  } fcsu_kind_t;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_FIRST  = 7'b0000010,
    ST_SECOND = 7'b0000100,
    ST_FIX    = 7'b0001000,
    ST_READ   = 7'b0010000,
    ST_PWR    = 7'b0100000,
    ST_PRD    = 7'b1000000
  } fcsu_seq_t;

  typedef enum logic [3:0] {
    CY_IDLE  = 4'b0001,
    CY_SETUP = 4'b0010,
    CY_PULSE = 4'b0100,
    CY_HOLD  = 4'b1000
  } fcsu_cyc_t;

  typedef struct packed {
    logic        wr;
    logic [21:0] addr;
    logic [15:0] data;
  } fcsu_req_t;
endpackage

// *** tb/fcsu_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module fcsu_ctrl_tb_top;
  logic        i_core_clk;
  logic        i_rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [21:0] f_addr;
  logic        f_ce_b;
  logic        f_oe_b;
  logic        f_we_b;
  logic [15:0] f_dq;
  logic        f_dq_oe;
  logic [15:0] m_dq;
  logic [15:0] dq_w;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] s;
  logic [21:0] a;
  logic [21:0] b;
  logic [15:0] d;
  int          num_errors;
  int          checks;
  int          cyc;

  assign dq_w = f_dq_oe ? f_dq : m_dq;

  fcsu_ctrl dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .i_dq(dq_w), .o_addr(f_addr),
    .o_ce_b(f_ce_b), .o_oe_b(f_oe_b), .o_we_b(f_we_b), .o_dq(f_dq),
    .o_dq_oe(f_dq_oe));

  fcsu_flash_model m (.i_addr(f_addr), .i_ce_b(f_ce_b), .i_oe_b(f_oe_b),
    .i_we_b(f_we_b), .i_dq(dq_w), .o_dq(m_dq));

  //////////////////////////////////////////////////////////////////////////
  always #12.5 i_core_clk = ~i_core_clk;

  // every operation is under a hundred cycles; this leaves wide margin
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [31:0] ad, wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= ad;
    hwrite <= w;
    do @(posedge i_core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // load address and data, issue the order, then poll busy with a bound
  task automatic run(input logic [7:0] c, input logic [1:0] k,
                     input logic [21:0] ad, input logic [15:0] w);
    int n;
    bus(1'b1, 32'h04, {10'h0, ad}, r);
    bus(1'b1, 32'h08, {16'h0, w}, r);
    bus(1'b1, 32'h00, {22'h0, k, c}, r);
    @(posedge i_core_clk);
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 300) begin
      bus(1'b0, 32'h0c, 32'h0, s);
      n++;
    end
    if (n == 300) chk("busy", 32'h0, s);
  endtask

  task automatic fst(input logic [31:0] e);
    bus(1'b0, 32'h14, 32'h0, r);
    chk("flash status", e, r);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    i_rst_b = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    seed = 32'h4a26;
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge i_core_clk);
    bus(1'b0, 32'h20, 32'h0, r);
    chk("unmapped", 32'h0, r);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      a = r[21:0];
      r = xs();
      d = r[15:0];
      m.slow = i;
      run(8'h60, 2'h1, a, 16'h00d0);
      chk("unlock", 32'h84, s);
      run(i[0] ? 8'h10 : 8'h40, 2'h1, a, d);
      chk("program", 32'h84, s);
      fst(32'h80);
      run(8'hff, 2'h2, a, 16'h0);
      chk("read", 32'h04, s);
      bus(1'b0, 32'h10, 32'h0, r);
      chk("array", {16'h0, d}, r);
    end
    run(8'h60, 2'h1, a, 16'h0001);
    run(8'h40, 2'h1, a, ~d);
    chk("locked", 32'hc4, s);
    fst(32'h82);
    run(8'hff, 2'h2, a, 16'h0);
    bus(1'b0, 32'h10, 32'h0, r);
    chk("kept", {16'h0, d}, r);
    run(8'h50, 2'h0, a, 16'h0);
    run(8'h70, 2'h3, a, 16'h0);
    fst(32'h80);
    run(8'h60, 2'h1, a, 16'h002f);
    run(8'h60, 2'h1, a, 16'h00d0);
    run(8'h40, 2'h1, a, d);
    chk("lock-down", 32'hc4, s);
    b = a ^ 22'h200000;
    run(8'h60, 2'h1, b, 16'h00d0);
    m.pfail = 1'b1;
    run(8'h40, 2'h1, b, d);
    // the lock fault of the lock-down attempt is sticky until cleared
    chk("prog fail", 32'hcc, s);
    fst(32'h92);
    m.pfail = 1'b0;
    m.efail = 1'b1;
    run(8'h50, 2'h0, b, 16'h0);
    run(8'h20, 2'h1, b, 16'h00d0);
    chk("erase fail", 32'h94, s);
    fst(32'ha0);
    m.efail = 1'b0;
    m.vlow = 1'b1;
    run(8'h50, 2'h0, b, 16'h0);
    run(8'h40, 2'h1, b, d);
    fst(32'h88);
    m.vlow = 1'b0;
    run(8'h50, 2'h0, b, 16'h0);
    for (int i = 0; i < 4; i++) begin
      run(i[0] ? 8'h98 : 8'h90, 2'h0, b, 16'h0);
      chk("id or query", 32'h84, s);
    end
    // a background operation in the model, suspended then resumed
    for (int i = 0; i < 2; i++) begin
      m.p = i[0] ? 8'h20 : 8'h40;
      m.busy = 40;
      run(8'hb0, 2'h0, b, 16'h0);
      run(8'h70, 2'h3, b, 16'h0);
      fst(i[0] ? 32'hc0 : 32'h84);
      run(8'hd0, 2'h0, b, 16'h0);
      run(8'h70, 2'h3, b, 16'h0);
      fst(32'h80);
    end
    run(8'h00, 2'h0, b, 16'h0);
    chk("reserved", 32'h86, s);
    run(8'h60, 2'h1, b, 16'h0055);
    chk("bad confirm", 32'h86, s);
    close_out();
  end
endmodule

// *** tb/fcsu_flash_model.sv ***
`timescale 1ns/1ps
module fcsu_flash_model (
  input  wire logic [21:0] i_addr, // address pins
  input  wire logic        i_ce_b, // chip enable, active low
  input  wire logic        i_oe_b, // output enable, active low
  input  wire logic        i_we_b, // write enable, active low
  input  wire logic [15:0] i_dq,   // resolved data wire
  output logic      [15:0] o_dq    // device drive, inverse of last read when released
);
  logic [15:0] mem [logic [21:0]];
  logic [1:0]  lk [128];
  logic [7:0]  sr;
  logic [7:0]  pend;
  logic [7:0]  p;
  logic [6:0]  b;
  logic [1:0]  mode;
  logic [15:0] prot;
  logic [15:0] last;
  logic        pfail;
  logic        efail;
  logic        vlow;
  int          slow;
  int          busy;

  initial begin
    foreach (lk[i]) lk[i] = 2'b01;
    sr = 8'h00;
    {pend, mode, prot, last, pfail, efail, vlow} = '0;
    slow = 0;
    busy = 0;
  end

  // bit 0 reads as one on purpose: the controller has to mask it
  function automatic logic [15:0] rdv(input logic [21:0] a,
                                      input logic [1:0] md, input int bz);
    case (md)
      2'h0: return mem.exists(a) ? mem[a] : 16'hffff;
      2'h1: return {8'h00, bz == 0, sr[6:1], 1'b1};
      2'h2: return {14'h0, lk[a[21:15]]};
      default: return 16'h0051;
    endcase
  endfunction

  // a released bus shows the inverse of the last value, not a hold
  assign o_dq = (!i_ce_b && !i_oe_b) ? rdv(i_addr, mode, busy) : ~last;

  always @(posedge i_oe_b) begin
    if (!i_ce_b) begin
      last = rdv(i_addr, mode, busy);
      if (mode == 2'h1 && busy > 0) busy--;
    end
  end

  always @(posedge i_we_b) begin
    if (!i_ce_b) begin
      b = i_addr[21:15];
      if (pend == 8'h60) begin
        pend = 0;
        case (i_dq[7:0])
          8'h01: lk[b][0] = 1'b1;
          8'h2f: lk[b] = 2'b11;
          8'hd0: if (!lk[b][1]) lk[b][0] = 1'b0;
          default: begin
            sr[5:4] = 2'b11;
            mode = 2'h1;
          end
        endcase
      end else if (pend != 0) begin
        p = pend;
        pend = 0;
        mode = 2'h1;
        busy = slow;
        if (vlow) sr[3] = 1'b1;
        else if (p != 8'hc0 && lk[b][0]) sr[1] = 1'b1;
        else if (p == 8'h20) sr[5] = efail;
        else if (pfail) sr[4] = 1'b1;
        else if (p == 8'hc0) prot = i_dq;
        else mem[i_addr] = i_dq;
      end else begin
        case (i_dq[7:0])
          8'hff: mode = 2'h0;
          8'h70: mode = 2'h1;
          8'h50: sr = sr & 8'hc4;
          8'h90: mode = 2'h2;
          8'h98: mode = 2'h3;
          8'h60, 8'h40, 8'h10, 8'h20, 8'hc0: pend = i_dq[7:0];
          // a suspend only takes hold while an operation is running
          8'hb0: if (busy > 0) begin
            if (p == 8'h20) sr[6] = 1'b1;
            else sr[2] = 1'b1;
            busy = 0;
            mode = 2'h1;
          end
          8'hd0: sr = sr & 8'hbb;
          default: ;
        endcase
      end
    end
  end
endmodule
